// ### logic/pdv_pkg.sv
package pdv_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_C0     = 8'h92;
  localparam logic [7:0] ADDR_C1     = 8'h93;
  localparam logic [7:0] ADDR_C2     = 8'h94;
  localparam logic [7:0] ADDR_D0     = 8'h95;
  localparam logic [7:0] ADDR_D1     = 8'h96;
  localparam logic [7:0] ADDR_D2     = 8'h97;
  localparam logic [7:0] ADDR_STATUS = 8'h98;
  localparam logic [23:0] CFG_RESET  = 24'h000032;

  // ----------------------------------------------------------------
  // Field layout and codes
  // ----------------------------------------------------------------
  localparam int          MODE_LSB  = 20;
  localparam int          STYLE_BIT = 19;
  localparam int          POL_BIT   = 18;
  localparam int          SRC_LSB   = 16;
  localparam logic [3:0]  MODE_FP   = 4'hF;
  localparam logic [1:0]  SRC_A     = 2'h0;
  localparam logic [1:0]  SRC_B     = 2'h1;
  localparam logic [1:0]  LF_CODE_C = 2'h2;
  localparam logic [1:0]  LF_CODE_D = 2'h3;
  localparam logic [2:0]  MASK_ALL  = 3'h7;
  localparam logic [23:0] DIV_MIN   = 24'h000002;
  localparam logic [15:0] LF_MIN    = 16'h0002;
  localparam logic [15:0] RATE_MIN  = 16'h0001;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] cnt;
    logic        pulse;
    logic        prev_sel;
    logic        out;
  } pdv_chan_t;

  typedef struct packed {
    logic [23:0] cfg_c;
    logic [23:0] cfg_d;
    logic [23:0] shad_c;
    logic [23:0] shad_d;
    logic [2:0]  mask_c;
    logic [2:0]  mask_d;
    logic [7:0]  rdata;
    pdv_chan_t   ch_c;
    pdv_chan_t   ch_d;
  } pdv_state_t;

endpackage

// ### logic/pdv_post_div.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module pdv_post_div (
  input  wire logic       ref_clk_i,  // Synthesizer clock, 10 MHz.
  input  wire logic       sys_rst_i,  // Synchronous reset, active high.
  input  wire logic       base_tick_i,// One-cycle tick at twice the base rate.
  input  wire logic       clk_a_i,    // Sibling post-divider A level.
  input  wire logic       clk_b_i,    // Sibling post-divider B level.
  input  wire logic [7:0] addr_i,     // Register byte address.
  input  wire logic [7:0] wdata_i,    // Register write data.
  input  wire logic       wr_i,       // Write strobe.
  input  wire logic       rd_i,       // Read strobe.
  output logic      [7:0] rdata_o,    // Read data, one cycle after the strobe.
  output logic            out_c_o,    // Output C.
  output logic            out_d_o     // Output D.
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Replaces one byte of a 24-bit shadow value.
  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] idx,
                                           input logic [7:0] d);
    logic [23:0] r;
    r = v;
    r[idx*8 +: 8] = d;
    return r;
  endfunction

  // Advances one output channel by one clock.
  function automatic pdv_pkg::pdv_chan_t step(input pdv_pkg::pdv_chan_t s,
                                              input logic [23:0] cfg, input logic sel,
                                              input logic tick, input logic [1:0] lf_code);
    pdv_pkg::pdv_chan_t n;
    logic [23:0] div;
    logic [15:0] lim;
    n = s;
    n.prev_sel = sel;
    div = pdv_pkg::DIV_MIN;
    lim = pdv_pkg::LF_MIN;
    if (cfg[pdv_pkg::MODE_LSB +: 4] != pdv_pkg::MODE_FP) begin
      // Whole 24 bits, style and polarity bits included, form the ratio.
      div = (cfg < pdv_pkg::DIV_MIN) ? pdv_pkg::DIV_MIN : cfg;
      n.cnt = (s.cnt >= div - 24'h1) ? 24'h0 : s.cnt + 24'h1;
      // High for the lower half, so odd ratios lose one cycle of high time.
      n.out = n.cnt < (div >> 1);
      n.pulse = 1'b0;
    end else if (cfg[pdv_pkg::SRC_LSB +: 2] == lf_code) begin
      // Low-rate clock counted on the doubled base tick.
      if (tick) begin
        lim = (cfg[15:0] < pdv_pkg::LF_MIN) ? pdv_pkg::LF_MIN : cfg[15:0];
        n.cnt = (s.cnt >= {8'h0, lim} - 24'h1) ? 24'h0 : s.cnt + 24'h1;
        n.out = n.cnt < {9'h0, lim[15:1]};
      end
      n.pulse = 1'b0;
    end else begin
      // Frame pulse timed by the sibling clock's edges.
      lim = (cfg[15:0] < pdv_pkg::RATE_MIN) ? pdv_pkg::RATE_MIN : cfg[15:0];
      if (sel && !s.prev_sel) begin
        n.cnt = (s.cnt >= {8'h0, lim} - 24'h1) ? 24'h0 : s.cnt + 24'h1;
        if (cfg[pdv_pkg::STYLE_BIT]) begin
          // Pulse spans the period that opens at the boundary.
          n.pulse = (n.cnt == 24'h0);
        end
      end else if (!sel && s.prev_sel && !cfg[pdv_pkg::STYLE_BIT]) begin
        // Pulse spans falling edge to falling edge around the boundary.
        n.pulse = (s.cnt == {8'h0, lim} - 24'h1);
      end
      n.out = n.pulse ^ cfg[pdv_pkg::POL_BIT];
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State and source selection
  // ----------------------------------------------------------------
  pdv_pkg::pdv_state_t st;
  pdv_pkg::pdv_state_t next_st;
  logic                sel_c;
  logic                sel_d;
  logic                frame_c;
  logic                frame_d;
  logic                lf_c;
  logic                lf_d;

  // Sibling clock chosen for each output.
  always_comb begin
    unique case (st.cfg_c[pdv_pkg::SRC_LSB +: 2])
      pdv_pkg::SRC_A: sel_c = clk_a_i;
      pdv_pkg::SRC_B: sel_c = clk_b_i;
      pdv_pkg::LF_CODE_C: sel_c = 1'b0;
      pdv_pkg::LF_CODE_D: sel_c = st.ch_d.out;
    endcase
    unique case (st.cfg_d[pdv_pkg::SRC_LSB +: 2])
      pdv_pkg::SRC_A: sel_d = clk_a_i;
      pdv_pkg::SRC_B: sel_d = clk_b_i;
      pdv_pkg::LF_CODE_C: sel_d = st.ch_c.out;
      pdv_pkg::LF_CODE_D: sel_d = 1'b0;
    endcase
  end

  // Mode decode, used by the checks below.
  assign lf_c    = (st.cfg_c[pdv_pkg::MODE_LSB +: 4] == pdv_pkg::MODE_FP) &&
                   (st.cfg_c[pdv_pkg::SRC_LSB +: 2] == pdv_pkg::LF_CODE_C);
  assign lf_d    = (st.cfg_d[pdv_pkg::MODE_LSB +: 4] == pdv_pkg::MODE_FP) &&
                   (st.cfg_d[pdv_pkg::SRC_LSB +: 2] == pdv_pkg::LF_CODE_D);
  assign frame_c = (st.cfg_c[pdv_pkg::MODE_LSB +: 4] == pdv_pkg::MODE_FP) && !lf_c;
  assign frame_d = (st.cfg_d[pdv_pkg::MODE_LSB +: 4] == pdv_pkg::MODE_FP) && !lf_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Register writes collect in shadows and commit once complete.
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        pdv_pkg::ADDR_C0, pdv_pkg::ADDR_C1, pdv_pkg::ADDR_C2: begin
          next_st.shad_c = put_byte(st.shad_c, 2'(addr_i - pdv_pkg::ADDR_C0), wdata_i);
          next_st.mask_c = st.mask_c | (3'h1 << 2'(addr_i - pdv_pkg::ADDR_C0));
        end
        pdv_pkg::ADDR_D0, pdv_pkg::ADDR_D1, pdv_pkg::ADDR_D2: begin
          next_st.shad_d = put_byte(st.shad_d, 2'(addr_i - pdv_pkg::ADDR_D0), wdata_i);
          next_st.mask_d = st.mask_d | (3'h1 << 2'(addr_i - pdv_pkg::ADDR_D0));
        end
        default: begin
        end
      endcase
    end
    // Commit only after all three bytes arrive.
    if (next_st.mask_c == pdv_pkg::MASK_ALL) begin
      next_st.cfg_c  = next_st.shad_c;
      next_st.mask_c = 3'h0;
    end
    if (next_st.mask_d == pdv_pkg::MASK_ALL) begin
      next_st.cfg_d  = next_st.shad_d;
      next_st.mask_d = 3'h0;
    end
    if (rd_i) begin
      unique case (addr_i)
        pdv_pkg::ADDR_C0: next_st.rdata = st.cfg_c[7:0];
        pdv_pkg::ADDR_C1: next_st.rdata = st.cfg_c[15:8];
        pdv_pkg::ADDR_C2: next_st.rdata = st.cfg_c[23:16];
        pdv_pkg::ADDR_D0: next_st.rdata = st.cfg_d[7:0];
        pdv_pkg::ADDR_D1: next_st.rdata = st.cfg_d[15:8];
        pdv_pkg::ADDR_D2: next_st.rdata = st.cfg_d[23:16];
        pdv_pkg::ADDR_STATUS: next_st.rdata = {4'h0, st.mask_d != 3'h0,
                                               st.mask_c != 3'h0, st.ch_d.out, st.ch_c.out};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.ch_c = step(st.ch_c, st.cfg_c, sel_c, base_tick_i, pdv_pkg::LF_CODE_C);
    next_st.ch_d = step(st.ch_d, st.cfg_d, sel_d, base_tick_i, pdv_pkg::LF_CODE_D);
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st        <= '0;
      st.cfg_c  <= pdv_pkg::CFG_RESET;
      st.cfg_d  <= pdv_pkg::CFG_RESET;
      st.shad_c <= pdv_pkg::CFG_RESET;
      st.shad_d <= pdv_pkg::CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata_o = st.rdata;
  assign out_c_o = st.ch_c.out;
  assign out_d_o = st.ch_d.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // A lone first byte never changes the live value.
  partial_write_a: assert property (wr_i && addr_i == pdv_pkg::ADDR_C0 && st.mask_c == 3'h0
    |=> $stable(st.cfg_c)) else $error("partial write changed output C setting");

  // Divide by two toggles every cycle once settled.
  div_two_a: assert property ((st.cfg_c == 24'h000002) [*3]
    |-> out_c_o != $past(out_c_o)) else $error("output C not toggling at divide two");

  // Low-rate clock moves only on a base tick.
  lf_hold_c_a: assert property (lf_c && !base_tick_i
    |=> out_c_o == $past(out_c_o)) else $error("output C low-rate clock moved without tick");

  // Frame output equals pulse state through the polarity bit.
  frame_pol_a: assert property (frame_c && $stable(st.cfg_c)
    |-> out_c_o == (st.ch_c.pulse ^ st.cfg_c[pdv_pkg::POL_BIT]))
    else $error("output C frame polarity wrong");

  // First-edge style starts on a sibling rising edge.
  style_edge_a: assert property (frame_c && st.cfg_c[pdv_pkg::STYLE_BIT] &&
    $stable(st.cfg_c) && $rose(st.ch_c.pulse) |-> $past(sel_c) && !$past(st.ch_c.prev_sel))
    else $error("first-edge pulse not on rising edge");

  // Mid-pulse style starts on a sibling falling edge.
  style_mid_a: assert property (frame_c && !st.cfg_c[pdv_pkg::STYLE_BIT] &&
    $stable(st.cfg_c) && $rose(st.ch_c.pulse) |-> !$past(sel_c) && $past(st.ch_c.prev_sel))
    else $error("mid-pulse frame not on falling edge");

  // Output D low-rate clock moves only on a base tick.
  lf_hold_d_a: assert property (lf_d && !base_tick_i
    |=> out_d_o == $past(out_d_o)) else $error("output D low-rate clock moved without tick");

  // Output D with source C starts first-edge pulses on a rise of output C.
  d_src_c_a: assert property (frame_d && st.cfg_d[pdv_pkg::SRC_LSB +: 2] == 2'h2 &&
    st.cfg_d[pdv_pkg::STYLE_BIT] && $stable(st.cfg_d) && $rose(st.ch_d.pulse)
    |-> $past(out_c_o, 2) == 1'b0 && $past(out_c_o) == 1'b1)
    else $error("output D pulse not timed from output C");

  // Pulse count of one fires a pulse on every sibling period.
  rate_one_a: assert property (frame_d && st.cfg_d[15:0] == 16'h0001 &&
    st.cfg_d[pdv_pkg::STYLE_BIT] && $stable(st.cfg_d) && sel_d && !st.ch_d.prev_sel
    |=> st.ch_d.pulse) else $error("output D rate of one missed a pulse");

  // A lone first byte of output D never changes its live value.
  partial_d_a: assert property (wr_i && addr_i == pdv_pkg::ADDR_D0 && st.mask_d == 3'h0
    |=> $stable(st.cfg_d)) else $error("partial write changed output D setting");

  // The third byte commits the shadow together with the byte just written.
  commit_c_a: assert property (wr_i && addr_i == pdv_pkg::ADDR_C2 && st.mask_c == 3'h3
    |=> st.cfg_c == {$past(wdata_i), $past(st.shad_c[15:0])})
    else $error("output C setting not committed on last byte");

  // Read data stand only in the cycle after a read strobe.
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data present without a read strobe");

  // The top byte of output D reads back the live value.
  rd_top_d_a: assert property (rd_i && addr_i == pdv_pkg::ADDR_D2
    |=> rdata_o == $past(st.cfg_d[23:16])) else $error("output D top byte read back wrong");

  // In divide mode the counter of output C stays below the ratio.
  div_range_c_a: assert property (st.cfg_c[pdv_pkg::MODE_LSB +: 4] != pdv_pkg::MODE_FP &&
    st.cfg_c >= pdv_pkg::DIV_MIN && $stable(st.cfg_c) |-> st.ch_c.cnt < st.cfg_c)
    else $error("output C counter beyond its ratio");

  // In divide mode the counter of output D stays below the whole 24-bit ratio.
  div_range_d_a: assert property (st.cfg_d[pdv_pkg::MODE_LSB +: 4] != pdv_pkg::MODE_FP &&
    st.cfg_d >= pdv_pkg::DIV_MIN && $stable(st.cfg_d) |-> st.ch_d.cnt < st.cfg_d)
    else $error("output D counter beyond its ratio");

  // Outside frame mode no pulse state survives, so bits 19:18 act as ratio bits.
  pulse_clr_a: assert property (st.cfg_c[pdv_pkg::MODE_LSB +: 4] != pdv_pkg::MODE_FP
    |=> !st.ch_c.pulse) else $error("output C pulse state outside frame mode");

  // Output D frame level equals pulse state through its polarity bit.
  frame_pol_d_a: assert property (frame_d && $stable(st.cfg_d)
    |-> out_d_o == (st.ch_d.pulse ^ st.cfg_d[pdv_pkg::POL_BIT]))
    else $error("output D frame polarity wrong");

  frame_seen_c: cover property (frame_c && $rose(st.ch_c.pulse));
  lf_seen_d: cover property (lf_d && $changed(out_d_o));
  commit_seen_c: cover property (wr_i && st.mask_c == 3'h3 && addr_i == pdv_pkg::ADDR_C2);
  neg_pulse_d: cover property (frame_d && st.cfg_d[pdv_pkg::POL_BIT] && $fell(out_d_o));
  commit_seen_d: cover property (wr_i && st.mask_d == 3'h3 && addr_i == pdv_pkg::ADDR_D2);

endmodule  // pdv_post_div

// ### dv/synth_post_divider_frame_pulse_test.sv
`timescale 1ns/1ps
module synth_post_divider_frame_pulse_test;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic       ref_clk_i   = 1'b0;
  logic       sys_rst_i   = 1'b1;
  logic       base_tick_i = 1'b0;
  logic       clk_a_i     = 1'b0;
  logic       clk_b_i     = 1'b0;
  logic [7:0] addr_i      = 8'h00;
  logic [7:0] wdata_i     = 8'h00;
  logic       wr_i        = 1'b0;
  logic       rd_i        = 1'b0;
  logic [7:0] rdata_o;
  logic       out_c_o;
  logic       out_d_o;
  int         cyc         = 0;
  int         failures    = 0;
  int         comparisons = 0;

  pdv_post_div u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .base_tick_i(base_tick_i),
    .clk_a_i(clk_a_i), .clk_b_i(clk_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .out_c_o(out_c_o), .out_d_o(out_d_o));

  // Clock of 100 ns.
  always #50 ref_clk_i = ~ref_clk_i;

  // Sibling clocks of 4 and 6 cycles and a rate tick every 5 cycles.
  always @(posedge ref_clk_i) begin
    cyc         <= cyc + 1;
    clk_a_i     <= (cyc % 4) < 2;
    clk_b_i     <= (cyc % 6) < 3;
    base_tick_i <= (cyc % 5) == 0;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares a seen value with the expected one and counts both.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Writes one byte; each strobe is followed by one idle cycle.
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    // One idle edge so that a following call never re-raises the strobe in this step.
    @(posedge ref_clk_i);
  endtask

  // Writes the three bytes of a setting with no gap between them.
  task automatic wr_cfg(input logic [7:0] base, input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      wr_i <= 1'b1; addr_i <= base + 8'(i); wdata_i <= v[8*i +: 8];
      @(posedge ref_clk_i);
    end
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Reads a byte; data are taken in the cycle after the strobe.
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
    d = rdata_o;
  endtask

  function automatic logic outv(input bit d);
    return d ? out_d_o : out_c_o;
  endfunction

  // Waits for an output level under a bounded count.
  task automatic wait_lvl(input bit d, input logic v);
    int n;
    n = 0;
    while (outv(d) !== v && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 3000) check(24'(outv(d)), 24'(v));
  endtask

  // Skips a settling period, then counts high and low cycles.
  task automatic meas(input bit d, input int hi, input int lo);
    int h;
    int l;
    h = 0;
    l = 0;
    wait_lvl(d, 1'b0); wait_lvl(d, 1'b1); wait_lvl(d, 1'b0); wait_lvl(d, 1'b1);
    while (outv(d) === 1'b1 && h < 3000) begin @(posedge ref_clk_i); h++; end
    while (outv(d) === 1'b0 && l < 3000) begin @(posedge ref_clk_i); l++; end
    check(24'(h), 24'(hi));
    check(24'(l), 24'(lo));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, read-back and the unmapped place.
  task automatic t_regs();
    logic [7:0] d;
    rd_byte(pdv_pkg::ADDR_C0, d); check(24'(d), 24'h32);
    rd_byte(pdv_pkg::ADDR_D2, d); check(24'(d), 24'h00);
    wr_byte(8'h99, 8'h5A);
    rd_byte(8'h99, d); check(24'(d), 24'h00);
  endtask

  // A partial write leaves the live value alone until the last byte.
  task automatic t_partial();
    logic [7:0] d;
    wr_byte(pdv_pkg::ADDR_C0, 8'h04);
    wr_byte(pdv_pkg::ADDR_C1, 8'h00);
    rd_byte(pdv_pkg::ADDR_C0, d); check(24'(d), 24'h32);
    rd_byte(pdv_pkg::ADDR_STATUS, d); check(24'(d[2]), 24'h1);
    wr_byte(pdv_pkg::ADDR_C2, 8'h00);
    rd_byte(pdv_pkg::ADDR_C0, d); check(24'(d), 24'h04);
  endtask

  // Divided clocks, even and odd, including the 7 and 8 cases.
  task automatic t_divide();
    logic [23:0] n [4] = '{24'h000002, 24'h000004, 24'h000007, 24'h000008};
    for (int i = 0; i < 4; i++) begin
      wr_cfg(pdv_pkg::ADDR_C0, n[i]);
      meas(1'b0, int'(n[i]) / 2, int'(n[i]) - int'(n[i]) / 2);
      wr_cfg(pdv_pkg::ADDR_D0, n[i]);
      meas(1'b1, int'(n[i]) / 2, int'(n[i]) - int'(n[i]) / 2);
    end
  endtask

  // Style and polarity bits act as divide bits: no short pulse appears.
  task automatic t_plain_bits();
    int t;
    t = 0;
    wr_cfg(pdv_pkg::ADDR_C0, 24'h0C0003);
    repeat (4) @(posedge ref_clk_i);
    while (out_c_o === 1'b1 && t < 200) begin @(posedge ref_clk_i); t++; end
    check(24'(t), 24'd200);
  endtask

  // Low-rate clocks counted in ticks of 5 cycles.
  task automatic t_low_rate();
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF20004);
    meas(1'b0, 10, 10);
    wr_cfg(pdv_pkg::ADDR_D0, 24'hF30004);
    meas(1'b1, 10, 10);
  endtask

  // Frame pulses of every source, both polarities and both styles.
  task automatic t_frame();
    int p0;
    int p1;
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF00003);
    meas(1'b0, 4, 8);
    p0 = cyc % 4;
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF40003);
    meas(1'b0, 8, 4);
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF80003);
    meas(1'b0, 4, 8);
    p1 = cyc % 4;
    check(24'((p0 - p1 + 4) % 4), 24'h2);
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF10002);
    meas(1'b0, 6, 6);
    wr_cfg(pdv_pkg::ADDR_D0, 24'hF00003);
    meas(1'b1, 4, 8);
    wr_cfg(pdv_pkg::ADDR_D0, 24'hF10003);
    meas(1'b1, 6, 12);
    wr_cfg(pdv_pkg::ADDR_C0, 24'h000004);
    wr_cfg(pdv_pkg::ADDR_D0, 24'hFA0003);
    meas(1'b1, 4, 8);
    wr_cfg(pdv_pkg::ADDR_D0, 24'h000004);
    wr_cfg(pdv_pkg::ADDR_C0, 24'hF30003);
    meas(1'b0, 4, 8);
    wr_cfg(pdv_pkg::ADDR_D0, 24'hF80001);
    repeat (12) @(posedge ref_clk_i);
    check(24'(out_d_o), 24'h1);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected thousand or so cycles.
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    failures++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_partial();
    t_divide();
    t_plain_bits();
    t_low_rate();
    t_frame();
    end_sim();
  end
endmodule // synth_post_divider_frame_pulse_test
